/* rpl_cfg.svh */
// Purpose: Constants for the RGB pixel input latch
// Assumes: Included by its bare name
// Notes: Offsets, widths, counts, the blank code and the clock period only, no logic
`ifndef RPL_CFG_SVH
`define RPL_CFG_SVH
`define RPL_CODE_W 8
`define RPL_NUM_CH 3
`define RPL_PIX_W 24
`define RPL_LEVELS 256
`define RPL_FIFO_DEPTH 8
`define RPL_WORD_W 26
`define RPL_SYNC_BIT 24
`define RPL_BLANK_BIT 25
`define RPL_CODE_BLANK 8'h00
`define RPL_CLK_PERIOD_NS 20
`endif

/* rpl_pkg.sv */
// Purpose: Types for the RGB pixel input latch
// Assumes: rpl_cfg.svh defines the widths
// Notes: Types only
`include "rpl_cfg.svh"
package rpl_pkg;
	typedef logic [`RPL_CODE_W-1:0] rpl_code_t;
	typedef enum logic [1:0] {
		RPL_LVL_SYNC = 2'b00,
		RPL_LVL_BLANK = 2'b01,
		RPL_LVL_VIDEO = 2'b10,
		RPL_LVL_SAVE = 2'b11
	} rpl_level_t;
endpackage : rpl_pkg

/* rpl_fifo.sv */
// Purpose: Small synchronous FIFO with valid and ready on both sides
// Assumes: One clock, asynchronous active high reset
// Notes: Read data comes combinationally from the storage array
`timescale 1ns/1ps
module rpl_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic push;
	logic pop;

	assign in_ready = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_ff[rd_ptr_ff];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
		count_ff == (AW+1)'(DEPTH) |-> !push)
		else $error("fifo pushed while full");
endmodule : rpl_fifo

/* rpl_top.sv */
// Purpose: Input register stage of a triple 8-bit video converter
// Assumes: Pixel, blank and sync pins are synchronous to MCLK
// Notes: Overview of operation follows
// Overview of operation
// - Every rising edge with CAPTURE_READY high captures all 24 pixel bits for the converters.
// - One 8-bit holding register per colour channel.
// - Blank and sync captured on the same edge as pixels.
// - Captured blank and sync select weighted output levels.
// - Each 8-bit code selects one of 256 levels.
// - Low power pin puts the outputs into a reduced power state.
// - Captured blank low forces blanking level, pixel bits ignored.
// - Bit zero is the least significant bit of each code.
`timescale 1ns/1ps
`include "rpl_cfg.svh"
module rpl_top
	import rpl_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// Pixel and control inputs
	input wire logic [7:0] RED_PIXEL_BITS,
	input wire logic [7:0] GREEN_PIXEL_BITS,
	input wire logic [7:0] BLUE_PIXEL_BITS,
	input wire logic BLANK_N,
	input wire logic SYNC_N,
	input wire logic LOW_POWER_PIN,
	// Converter side
	output logic [7:0] RED_CODE,
	output logic [7:0] GREEN_CODE,
	output logic [7:0] BLUE_CODE,
	output logic SYNC_CURRENT_ON,
	output logic [1:0] OUT_LEVEL,
	output logic POWER_SAVE,
	output logic CODE_VALID,
	input wire logic CONV_READY,
	output logic CAPTURE_READY
);
	// ****************************************************
	// Input capture
	// ****************************************************
	logic [`RPL_WORD_W-1:0] cap_word;
	logic [`RPL_WORD_W-1:0] fifo_word;
	logic fifo_valid;
	logic [7:0] pix_in [`RPL_NUM_CH];
	logic [7:0] hold_ff [`RPL_NUM_CH];
	logic sync_ff;
	logic blank_ff;
	logic low_power_ff;
	logic valid_ff;

	assign pix_in[0] = RED_PIXEL_BITS;
	assign pix_in[1] = GREEN_PIXEL_BITS;
	assign pix_in[2] = BLUE_PIXEL_BITS;
	// Blue in low byte, bit 0 of each byte is the code LSB
	assign cap_word = {BLANK_N, SYNC_N, pix_in[0],
		pix_in[1], pix_in[2]};

	// FIFO absorbs up to 8 words of converter back pressure; pixels are dropped while it is full
	rpl_fifo #(
		.WIDTH(`RPL_WORD_W),
		.DEPTH(`RPL_FIFO_DEPTH)
	) u_fifo (
		.clk(MCLK),
		.rst(RST),
		.in_valid(1'b1),
		.in_ready(CAPTURE_READY),
		.in_data(cap_word),
		.out_valid(fifo_valid),
		.out_ready(CONV_READY),
		.out_data(fifo_word)
	);

	// ****************************************************
	// Holding registers
	// ****************************************************
	genvar ch;
	generate
		for (ch = 0; ch < `RPL_NUM_CH; ch++) begin : g_hold
			localparam int LSB = (`RPL_NUM_CH - 1 - ch) * `RPL_CODE_W;
			always_ff @(posedge MCLK or posedge RST) begin
				if (RST) begin
					hold_ff[ch] <= `RPL_CODE_BLANK;
				end else if (fifo_valid && CONV_READY) begin
					// Pixel bits ignored while blanked
					hold_ff[ch] <= fifo_word[`RPL_BLANK_BIT] ?
						fifo_word[LSB +: `RPL_CODE_W] : `RPL_CODE_BLANK;
				end
			end
		end
	endgenerate

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			sync_ff <= 1'b0;
			blank_ff <= 1'b0;
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= fifo_valid && CONV_READY;
			if (fifo_valid && CONV_READY) begin
				sync_ff <= fifo_word[`RPL_SYNC_BIT];
				blank_ff <= fifo_word[`RPL_BLANK_BIT];
			end
		end
	end

	// Pin is asynchronous to the pixel stream
	logic low_power_meta_ff;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			low_power_meta_ff <= 1'b0;
			low_power_ff <= 1'b0;
		end else begin
			low_power_meta_ff <= LOW_POWER_PIN;
			low_power_ff <= low_power_meta_ff;
		end
	end

	// ****************************************************
	// Output level selection
	// ****************************************************
	rpl_level_t level;
	always_comb begin
		case ({low_power_ff, blank_ff, sync_ff})
			3'b000: level = RPL_LVL_SYNC;
			3'b001: level = RPL_LVL_BLANK;
			3'b010, 3'b011: level = RPL_LVL_VIDEO;
			default: level = RPL_LVL_SAVE;
		endcase
	end

	assign RED_CODE = hold_ff[0];
	assign GREEN_CODE = hold_ff[1];
	assign BLUE_CODE = hold_ff[2];
	// Sync never overrides data; drives the sync source and, while blanked, picks sync or blank level
	assign SYNC_CURRENT_ON = sync_ff && !low_power_ff;
	assign OUT_LEVEL = level;
	assign POWER_SAVE = low_power_ff;
	assign CODE_VALID = valid_ff;

	// ****************************************************
	// Checks
	// ****************************************************
	sequence s_take_blanked;
		fifo_valid && CONV_READY && !fifo_word[`RPL_BLANK_BIT];
	endsequence

	a_blank_forces_zero: assert property (@(posedge MCLK) disable iff (RST)
		s_take_blanked |=> (RED_CODE == 8'h00 && GREEN_CODE == 8'h00
			&& BLUE_CODE == 8'h00 && OUT_LEVEL != 2'b10))
		else $error("blanked pixel not forced to blank level");

	a_red_capture: assert property (@(posedge MCLK) disable iff (RST)
		fifo_valid && CONV_READY && fifo_word[`RPL_BLANK_BIT]
		|=> RED_CODE == $past(fifo_word[23:16]))
		else $error("red code not captured");

	a_blue_lsb: assert property (@(posedge MCLK) disable iff (RST)
		fifo_valid && CONV_READY && fifo_word[`RPL_BLANK_BIT]
		|=> BLUE_CODE[0] == $past(fifo_word[0]))
		else $error("blue lsb misplaced");

	a_ctrl_aligned: assert property (@(posedge MCLK) disable iff (RST)
		fifo_valid && CONV_READY |=> blank_ff == $past(fifo_word[25])
		&& sync_ff == $past(fifo_word[24]))
		else $error("controls not aligned with pixels");

	a_valid_timing: assert property (@(posedge MCLK) disable iff (RST)
		fifo_valid && CONV_READY |=> CODE_VALID)
		else $error("code valid late");

	a_low_power_sync: assert property (@(posedge MCLK) disable iff (RST)
		$rose(LOW_POWER_PIN) ##1 LOW_POWER_PIN |=> POWER_SAVE)
		else $error("power save not entered in two cycles");

	a_level_video: assert property (@(posedge MCLK) disable iff (RST)
		blank_ff && !low_power_ff |-> OUT_LEVEL == 2'h2)
		else $error("unblanked pixel not at video level");

	a_sync_source: assert property (@(posedge MCLK) disable iff (RST)
		POWER_SAVE |-> !SYNC_CURRENT_ON && OUT_LEVEL == 2'b11)
		else $error("sync source on during power save");

	a_hold_stable: assert property (@(posedge MCLK) disable iff (RST)
		!(fifo_valid && CONV_READY) |=> $stable(GREEN_CODE))
		else $error("green holding register changed without capture");

	a_red_stable: assert property (@(posedge MCLK) disable iff (RST)
		!(fifo_valid && CONV_READY) |=> $stable(RED_CODE))
		else $error("red holding register changed without capture");

	a_green_capture: assert property (@(posedge MCLK) disable iff (RST)
		fifo_valid && CONV_READY && fifo_word[`RPL_BLANK_BIT]
		|=> GREEN_CODE == $past(fifo_word[15:8]))
		else $error("green code not captured");

	a_blue_capture: assert property (@(posedge MCLK) disable iff (RST)
		fifo_valid && CONV_READY && fifo_word[`RPL_BLANK_BIT]
		|=> BLUE_CODE == $past(fifo_word[7:0]))
		else $error("blue code not captured");

	a_valid_single: assert property (@(posedge MCLK) disable iff (RST)
		!(fifo_valid && CONV_READY) |=> !CODE_VALID)
		else $error("code valid without a take");

	a_level_sync: assert property (@(posedge MCLK) disable iff (RST)
		!low_power_ff && !blank_ff && !sync_ff |-> OUT_LEVEL == RPL_LVL_SYNC)
		else $error("blank with sync low not at sync level");

	a_level_blank: assert property (@(posedge MCLK) disable iff (RST)
		!low_power_ff && !blank_ff && sync_ff |-> OUT_LEVEL == RPL_LVL_BLANK)
		else $error("blank with sync high not at blank level");

	a_sync_follows: assert property (@(posedge MCLK) disable iff (RST)
		!POWER_SAVE |-> SYNC_CURRENT_ON == sync_ff)
		else $error("sync source not following captured sync");

	sequence s_pin_low_held;
		$fell(LOW_POWER_PIN) ##1 !LOW_POWER_PIN;
	endsequence

	a_low_power_exit: assert property (@(posedge MCLK) disable iff (RST)
		s_pin_low_held |=> !POWER_SAVE)
		else $error("power save not left in two cycles");
endmodule : rpl_top

/* rpl_ctrl_model.sv */
// Purpose: Pixel controller model driving the latch pins
// Assumes: Pins change on the falling edge only
// Notes: Fixed 64-pixel line with 16 blanked pixels
`timescale 1ns/1ps
module rpl_ctrl_model (
	// Clock, reset, mode
	input wire logic clk,
	input wire logic rst,
	input wire logic sync_en,
	// Pixel pins
	output logic [7:0] red,
	output logic [7:0] green,
	output logic [7:0] blue,
	output logic blank_n,
	output logic sync_n
);
	logic [5:0] cnt_ff;
	logic blank;
	// Half a cycle of setup and hold around the capture edge
	always_ff @(negedge clk or posedge rst) begin
		if (rst)
			cnt_ff <= 6'h00;
		else
			cnt_ff <= cnt_ff + 6'h01;
	end
	assign blank = (cnt_ff[5:4] == 2'h3);
	assign red = {2'h2, cnt_ff};
	assign green = {cnt_ff, 2'h1};
	assign blue = ~{cnt_ff, 2'h0};
	assign blank_n = ~blank;
	// Sync pulse only inside blanking, tied low when unused
	assign sync_n = sync_en & ~(blank & (cnt_ff[3:2] == 2'h1));
endmodule : rpl_ctrl_model

/* tb_rpl_top.sv */
// Purpose: Self-checking bench for the pixel input latch
// Assumes: Model drives pins on the falling edge
// Notes: Words are predicted from pins seen just before each edge
`timescale 1ns/1ps
module tb_rpl_top
	import rpl_pkg::*;
;
	logic MCLK, RST, lp, crdy, sen;
	logic [7:0] rd, gr, bl, rc, gc, bc;
	logic bn, sn, sc, ps, cv, cap;
	logic [1:0] lvl;
	logic [25:0] exp_q[$];
	logic [25:0] w;
	logic skip;
	logic [1:0] exp_lvl;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	// ****************
	// Harness
	// ****************
	rpl_ctrl_model model (.clk(MCLK), .rst(RST), .sync_en(sen), .red(rd),
		.green(gr), .blue(bl), .blank_n(bn), .sync_n(sn));
	rpl_top uut (.MCLK(MCLK), .RST(RST), .RED_PIXEL_BITS(rd),
		.GREEN_PIXEL_BITS(gr), .BLUE_PIXEL_BITS(bl), .BLANK_N(bn),
		.SYNC_N(sn), .LOW_POWER_PIN(lp), .RED_CODE(rc), .GREEN_CODE(gc),
		.BLUE_CODE(bc), .SYNC_CURRENT_ON(sc), .OUT_LEVEL(lvl),
		.POWER_SAVE(ps), .CODE_VALID(cv), .CONV_READY(crdy),
		.CAPTURE_READY(cap));
	task check(input string nm, input logic [7:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task stop_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	initial begin
		MCLK = 0;
		forever #10 MCLK = ~MCLK;
	end
	always @(posedge MCLK) begin
		cycles++;
		if (cycles > 3000) begin
			miscompares++;
			stop_test();
		end
	end
	// Sample 1 ns before the edge so capture never races the FIFO
	always @(negedge MCLK) begin
		#9;
		if (RST === 1'b0 && cap === 1'b1)
			exp_q.push_back({bn, sn, rd, gr, bl});
	end
	always @(negedge MCLK) if (RST === 1'b0 && cv === 1'b1) begin
		if (exp_q.size() == 0)
			check("spare word", 8'h01, 8'h00);
		else begin
			w = exp_q.pop_front();
			check("red", rc, w[25] ? w[23:16] : 8'h00);
			check("green", gc, w[25] ? w[15:8] : 8'h00);
			check("blue", bc, w[25] ? w[7:0] : 8'h00);
			if (!skip) begin
				check("sync", {7'h00, sc}, {7'h00, w[24]});
				exp_lvl = w[25] ? RPL_LVL_VIDEO
					: w[24] ? RPL_LVL_BLANK : RPL_LVL_SYNC;
				check("level", {6'h00, lvl}, {6'h00, exp_lvl});
			end
		end
	end
	// ****************
	// Scenarios
	// ****************
	task run(input int n);
		repeat (n) @(negedge MCLK);
	endtask : run
	task stall_fill;
		crdy = 0;
		run(14);
		check("capture ready", {7'h00, cap}, 8'h00);
		crdy = 1;
		run(80);
		// Seven words stay parked after a full stall
		#2;
		check("backlog", 8'(exp_q.size()), 8'h07);
		run(1);
	endtask : stall_fill
	task power_save;
		skip = 1;
		lp = 1;
		run(6);
		check("power", {7'h00, ps}, 8'h01);
		check("ps level", {6'h00, lvl}, {6'h00, RPL_LVL_SAVE});
		check("ps sync", {7'h00, sc}, 8'h00);
		lp = 0;
		run(6);
		check("power off", {7'h00, ps}, 8'h00);
		skip = 0;
		run(40);
	endtask : power_save
	task mid_reset;
		RST = 1;
		#1;
		check("rst code", rc | gc | bc, 8'h00);
		check("rst valid", {6'h00, cv, ~cap}, 8'h00);
		check("rst level", {4'h0, lvl, sc, ps}, 8'h00);
		exp_q.delete();
		run(2);
		RST = 0;
		run(70);
	endtask : mid_reset
	initial begin
		RST = 1;
		lp = 0;
		crdy = 1;
		sen = 1;
		skip = 0;
		run(6);
		RST = 0;
		run(140);
		stall_fill();
		sen = 0;
		run(70);
		sen = 1;
		power_save();
		mid_reset();
		// Every word captured since the mid-test reset delivered except the one in flight
		#2;
		check("backlog", 8'(exp_q.size()), 8'h01);
		stop_test();
	end
endmodule : tb_rpl_top
